// ### core/lpcs_pkg.sv
// Constants, encodings and state types for the command and state logic
package lpcs_pkg;
  localparam int BANKS = 8;
  localparam int CLK_PERIOD_NS = 4;

  // Interval figures in ns, counts rounded up to whole cycles
  localparam int T_RP_NS = 18;
  localparam int T_RCD_NS = 18;
  localparam int T_MRR_NS = 8;
  localparam int T_MRW_NS = 20;
  localparam int T_RFCPB_NS = 60;
  localparam int T_RFCAB_NS = 130;
  localparam int T_XP_NS = 8;
  localparam int T_XSR_NS = 140;
  localparam int T_INIT5_NS = 10000;
  localparam int T_BURST_NS = 16;

  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRR_CYC = (T_MRR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRW_CYC = (T_MRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFCPB_CYC = (T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFCAB_CYC = (T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XP_CYC = (T_XP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XSR_CYC = (T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT5_CYC = (T_INIT5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_CYC = (T_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int BK_TMR_W = 6;
  localparam int DEV_TMR_W = 6;
  localparam int INIT_TMR_W = 12;

  // Rising-edge opcode {ca3,ca2,ca1,ca0}
  localparam logic [3:0] OP_MRW = 4'h0;
  localparam logic [3:0] OP_MRR = 4'h8;
  localparam logic [3:0] OP_REFPB = 4'h4;
  localparam logic [3:0] OP_REFAB = 4'hc;
  localparam logic [3:0] OP_BST = 4'h3;
  localparam logic [3:0] OP_PRE = 4'hb;
  localparam logic [1:0] OP_ACT2 = 2'h2;
  localparam logic [2:0] OP_WRITE3 = 3'h1;
  localparam logic [2:0] OP_READ3 = 3'h5;
  localparam logic [2:0] OP_SREF3 = 3'h4;
  localparam logic [2:0] OP_DPD3 = 3'h7;

  // Field positions
  localparam int CA_BA_LSB = 7;
  localparam int CA_AB_BIT = 4;
  localparam int CA_AP_BIT = 0;
  localparam logic [7:0] RESET_MA = 8'h3f;

  typedef enum logic [3:0] {
    DS_POWER_ON, DS_RESETTING, DS_NORMAL, DS_IDLE_PD, DS_ACT_PD, DS_RST_PD, DS_SREF, DS_DPD
  } lpcs_dev_t;

  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING, BK_PRECHARGING, BK_REFRESHING
  } lpcs_bank_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_MRW, CMD_MRR, CMD_REFPB, CMD_REFAB, CMD_ACT, CMD_WRITE, CMD_READ, CMD_PRE, CMD_BST, CMD_DPD
  } lpcs_cmd_t;
endpackage

// ### core/lpcs_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/1ns
`default_nettype none
module lpcs_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### core/lpcs_command_state.sv
// Command decode, power state and per-bank state tracking
//
// Summary of operation
// R01: Commands decoded from cs, ca0-3, cke only
// R02: Bank chosen by three bank address bits
// R03: Auto-precharge closes bank after burst ends
// R04: Self refresh, deep power-down exit asynchronous
// R05: Per-bank refresh only on eight-bank parts
// R06: Lowest column address bit forced zero
// R07: Cke fall with NOP enters power-down
// R08: Cke low holds power state, ignores commands
// R09: Cke rise with NOP leaves power-down
// R10: Reset power-down exit depends on init timer
// R11: Cke fall with encoding enters sref/dpd
// R12: Deep power-down exit goes to power-on
// R13: Controller sends NOPs during power-down exit
// R14: Controller sends NOPs during self-refresh exit
// R15: Controller toggles clock within exit intervals
// R16: Undefined state/command pairs flagged illegal
// R17: Bank transitions only with cke high, exits done
// R18: Idle bank transitions on activate/refresh/mode/precharge
// R19: Reset enters resetting; MRR there reads registers
// R20: Active bank transitions on read/write/MRR/precharge
// R21: Reading bank accepts read, write, burst stop
// R22: Writing bank accepts write, read, burst stop
// R23: Idle only after precharge period elapsed
// R24: Active only after activate delay elapsed
// R25: Burst stop ends most recent burst, any bank
// R26: Reset requested by mode write to reset register
// R27: NOP leaves all state unchanged; here bank timers still count down and bursts still end
`timescale 1ns/1ns
`default_nettype none
module lpcs_command_state (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Command bus, both halves registered at the rising edge
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [9:0] ca_r,
  input wire logic [9:0] ca_f,
  // Device state
  output lpcs_pkg::lpcs_dev_t dev_state,
  output logic init_done,
  output logic exit_wait,
  output logic cmd_illegal,
  // Bank status
  output logic [lpcs_pkg::BANKS-1:0] bank_idle,
  output logic [lpcs_pkg::BANKS-1:0] bank_open,
  output logic burst_busy,
  output logic burst_read,
  output logic [2:0] burst_bank,
  output logic [11:0] col_addr
);
  logic cke_prev;
  logic cke_sync;
  logic cke_sync_d;
  logic [lpcs_pkg::DEV_TMR_W-1:0] exit_tmr;
  logic [lpcs_pkg::DEV_TMR_W-1:0] mr_tmr;
  logic [lpcs_pkg::INIT_TMR_W-1:0] init_tmr;
  logic [lpcs_pkg::DEV_TMR_W-1:0] burst_tmr;
  logic burst_ap;
  lpcs_pkg::lpcs_bank_t bk_state [lpcs_pkg::BANKS];
  logic [lpcs_pkg::BK_TMR_W-1:0] bk_tmr [lpcs_pkg::BANKS];

  lpcs_pkg::lpcs_cmd_t cmd;
  logic [2:0] ba;
  logic [7:0] ma;
  logic cmd_slot;
  logic ready;
  logic all_idle;
  logic cke_fall;
  logic cke_rise;
  logic wake;
  logic burst_done;
  logic acc_act, acc_rd, acc_wr, acc_pre, acc_prea, acc_refpb, acc_refab;
  logic acc_mrr, acc_mrw, acc_rst, acc_bst;
  logic enter_pd, enter_sref, enter_dpd, pd_exit, sref_exit;
  logic next_illegal;

  function automatic lpcs_pkg::lpcs_cmd_t decode_cmd(input logic [3:0] op);
    lpcs_pkg::lpcs_cmd_t c;
    c = lpcs_pkg::CMD_NONE;
    if (op[1:0] == lpcs_pkg::OP_ACT2) begin
      c = lpcs_pkg::CMD_ACT;
    end else if (op[2:0] == lpcs_pkg::OP_WRITE3) begin
      c = lpcs_pkg::CMD_WRITE;
    end else if (op[2:0] == lpcs_pkg::OP_READ3) begin
      c = lpcs_pkg::CMD_READ;
    end else if (op[2:0] == lpcs_pkg::OP_DPD3) begin
      c = lpcs_pkg::CMD_DPD;
    end else if (op == lpcs_pkg::OP_MRW) begin
      c = lpcs_pkg::CMD_MRW;
    end else if (op == lpcs_pkg::OP_MRR) begin
      c = lpcs_pkg::CMD_MRR;
    end else if (op == lpcs_pkg::OP_REFPB) begin
      c = lpcs_pkg::CMD_REFPB;
    end else if (op == lpcs_pkg::OP_REFAB) begin
      c = lpcs_pkg::CMD_REFAB;
    end else if (op == lpcs_pkg::OP_PRE) begin
      c = lpcs_pkg::CMD_PRE;
    end else if (op == lpcs_pkg::OP_BST) begin
      c = lpcs_pkg::CMD_BST;
    end
    return c;
  endfunction

  // Banks that may take a column access; a precharge is also taken by an idle bank
  function automatic logic bank_open_st(input lpcs_pkg::lpcs_bank_t s);
    return (s == lpcs_pkg::BK_ACTIVE) || (s == lpcs_pkg::BK_READING) || (s == lpcs_pkg::BK_WRITING);
  endfunction

  // Clock may be stopped in these states, so cke is watched through a synchroniser
  lpcs_sync2 u_cke_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(cke),
    .q(cke_sync)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cke_prev <= 1'b0;
      cke_sync_d <= 1'b0;
    end else begin
      cke_prev <= cke;
      cke_sync_d <= cke_sync;
    end
  end

  assign cmd = decode_cmd(ca_r[3:0]); // see R01
  assign ba = ca_r[lpcs_pkg::CA_BA_LSB +: 3]; // see R02
  assign ma = {ca_f[1:0], ca_r[9:4]};
  assign cmd_slot = cke_prev && cke && !cs_n;
  assign ready = (exit_tmr == '0) && (mr_tmr == '0);
  assign cke_fall = cke_prev && !cke;
  assign cke_rise = !cke_prev && cke;
  assign wake = cke_sync && !cke_sync_d; // see R04
  assign burst_done = burst_busy && (burst_tmr == lpcs_pkg::DEV_TMR_W'(1));

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < lpcs_pkg::BANKS; b++) begin
      if (bk_state[b] != lpcs_pkg::BK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // Command acceptance and legality
  always_comb begin
    acc_act = 1'b0;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_pre = 1'b0;
    acc_prea = 1'b0;
    acc_refpb = 1'b0;
    acc_refab = 1'b0;
    acc_mrr = 1'b0;
    acc_mrw = 1'b0;
    acc_rst = 1'b0;
    acc_bst = 1'b0;
    enter_pd = 1'b0;
    enter_sref = 1'b0;
    enter_dpd = 1'b0;
    pd_exit = 1'b0;
    sref_exit = 1'b0;
    next_illegal = 1'b0;
    if (cmd_slot) begin
      if (!ready) begin
        next_illegal = 1'b1; // see R17
      end else if (dev_state == lpcs_pkg::DS_NORMAL) begin
        case (cmd)
          lpcs_pkg::CMD_ACT: begin
            acc_act = (bk_state[ba] == lpcs_pkg::BK_IDLE); // see R18
          end
          lpcs_pkg::CMD_READ: begin
            acc_rd = bank_open_st(bk_state[ba]) && !(burst_ap && burst_bank == ba); // see R20 R21 R22
          end
          lpcs_pkg::CMD_WRITE: begin
            acc_wr = bank_open_st(bk_state[ba]) && !(burst_ap && burst_bank == ba); // see R20 R21 R22
          end
          lpcs_pkg::CMD_PRE: begin
            if (ca_r[lpcs_pkg::CA_AB_BIT]) begin
              acc_prea = 1'b1;
            end else begin
              acc_pre = bank_open_st(bk_state[ba]) || (bk_state[ba] == lpcs_pkg::BK_IDLE);
            end
          end
          lpcs_pkg::CMD_REFPB: begin
            acc_refpb = (bk_state[ba] == lpcs_pkg::BK_IDLE); // see R05
          end
          lpcs_pkg::CMD_REFAB: begin
            acc_refab = all_idle;
          end
          lpcs_pkg::CMD_MRW: begin
            acc_rst = all_idle && (ma == lpcs_pkg::RESET_MA); // see R26
            acc_mrw = all_idle && (ma != lpcs_pkg::RESET_MA);
          end
          lpcs_pkg::CMD_MRR: begin
            acc_mrr = !burst_busy;
          end
          lpcs_pkg::CMD_BST: begin
            acc_bst = burst_busy; // see R25
          end
          default: begin
          end
        endcase
        next_illegal = !(acc_act || acc_rd || acc_wr || acc_pre || acc_prea || acc_refpb || acc_refab
                         || acc_mrr || acc_mrw || acc_rst || (cmd == lpcs_pkg::CMD_BST)); // see R16
      end else if (dev_state == lpcs_pkg::DS_POWER_ON) begin
        acc_rst = (cmd == lpcs_pkg::CMD_MRW) && (ma == lpcs_pkg::RESET_MA); // see R19
        next_illegal = !acc_rst;
      end else if (dev_state == lpcs_pkg::DS_RESETTING) begin
        acc_mrr = (cmd == lpcs_pkg::CMD_MRR); // see R19
        next_illegal = !acc_mrr;
      end else begin
        next_illegal = 1'b1;
      end
    end else if (cke_fall) begin
      if (cs_n && (dev_state == lpcs_pkg::DS_NORMAL || dev_state == lpcs_pkg::DS_RESETTING)) begin
        enter_pd = 1'b1; // see R07
      end else if (!cs_n && dev_state == lpcs_pkg::DS_NORMAL && all_idle && ready
                   && ca_r[2:0] == lpcs_pkg::OP_SREF3) begin
        enter_sref = 1'b1; // see R11
      end else if (!cs_n && dev_state == lpcs_pkg::DS_NORMAL && all_idle && ready
                   && ca_r[2:0] == lpcs_pkg::OP_DPD3) begin
        enter_dpd = 1'b1; // see R11
      end else begin
        next_illegal = 1'b1;
      end
    end else if (cke_rise && cs_n) begin
      pd_exit = (dev_state == lpcs_pkg::DS_IDLE_PD) || (dev_state == lpcs_pkg::DS_ACT_PD)
                || (dev_state == lpcs_pkg::DS_RST_PD);
    end
    if (dev_state == lpcs_pkg::DS_SREF && wake) begin
      sref_exit = 1'b1;
    end
  end

  // Device power state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_state <= lpcs_pkg::DS_POWER_ON;
    end else begin
      case (dev_state)
        lpcs_pkg::DS_POWER_ON: begin
          if (acc_rst) begin
            dev_state <= lpcs_pkg::DS_RESETTING;
          end
        end
        lpcs_pkg::DS_NORMAL: begin
          if (enter_pd) begin
            dev_state <= all_idle ? lpcs_pkg::DS_IDLE_PD : lpcs_pkg::DS_ACT_PD; // see R07
          end else if (enter_sref) begin
            dev_state <= lpcs_pkg::DS_SREF;
          end else if (enter_dpd) begin
            dev_state <= lpcs_pkg::DS_DPD;
          end else if (acc_rst) begin
            dev_state <= lpcs_pkg::DS_RESETTING;
          end
        end
        lpcs_pkg::DS_RESETTING: begin
          if (enter_pd) begin
            dev_state <= lpcs_pkg::DS_RST_PD;
          end else if (init_tmr == '0 && mr_tmr == '0) begin
            dev_state <= lpcs_pkg::DS_NORMAL;
          end
        end
        lpcs_pkg::DS_IDLE_PD, lpcs_pkg::DS_ACT_PD: begin
          if (pd_exit) begin
            dev_state <= lpcs_pkg::DS_NORMAL; // see R09
          end
        end
        lpcs_pkg::DS_RST_PD: begin
          if (pd_exit) begin
            dev_state <= (init_tmr == '0) ? lpcs_pkg::DS_NORMAL : lpcs_pkg::DS_RESETTING; // see R10
          end
        end
        lpcs_pkg::DS_SREF: begin
          if (sref_exit) begin
            dev_state <= lpcs_pkg::DS_NORMAL;
          end
        end
        lpcs_pkg::DS_DPD: begin
          if (wake) begin
            dev_state <= lpcs_pkg::DS_POWER_ON; // see R12
          end
        end
        default: begin
          dev_state <= lpcs_pkg::DS_POWER_ON;
        end
      endcase
    end
  end

  // Exit interval: commands refused until it runs out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exit_tmr <= '0;
    end else if (pd_exit) begin
      exit_tmr <= lpcs_pkg::DEV_TMR_W'(lpcs_pkg::XP_CYC); // see R13
    end else if (sref_exit) begin
      exit_tmr <= lpcs_pkg::DEV_TMR_W'(lpcs_pkg::XSR_CYC); // see R14
    end else if (exit_tmr != '0) begin
      exit_tmr <= exit_tmr - 1'b1;
    end
  end

  // Mode register access interval
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mr_tmr <= '0;
    end else if (acc_mrr) begin
      mr_tmr <= lpcs_pkg::DEV_TMR_W'(lpcs_pkg::MRR_CYC);
    end else if (acc_mrw) begin
      mr_tmr <= lpcs_pkg::DEV_TMR_W'(lpcs_pkg::MRW_CYC);
    end else if (mr_tmr != '0) begin
      mr_tmr <= mr_tmr - 1'b1;
    end
  end

  // Auto-initialisation keeps running through resetting power-down
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_tmr <= '0;
    end else if (acc_rst) begin
      init_tmr <= lpcs_pkg::INIT_TMR_W'(lpcs_pkg::INIT5_CYC); // see R19
    end else if (init_tmr != '0) begin
      init_tmr <= init_tmr - 1'b1;
    end
  end

  // Most recent burst; only one may run at a time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_busy <= 1'b0;
      burst_read <= 1'b0;
      burst_ap <= 1'b0;
      burst_bank <= '0;
      burst_tmr <= '0;
    end else if (acc_rd || acc_wr) begin
      burst_busy <= 1'b1;
      burst_read <= acc_rd;
      burst_ap <= ca_f[lpcs_pkg::CA_AP_BIT];
      burst_bank <= ba;
      burst_tmr <= lpcs_pkg::DEV_TMR_W'(lpcs_pkg::BURST_CYC);
    end else if (acc_bst || burst_done || ((acc_pre && ba == burst_bank) || acc_prea)) begin
      burst_busy <= 1'b0; // see R25
      burst_ap <= 1'b0;
      burst_tmr <= '0;
    end else if (burst_tmr != '0) begin
      burst_tmr <= burst_tmr - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      col_addr <= '0;
    end else if (acc_rd || acc_wr) begin
      col_addr <= {ca_f[9:1], ca_r[6:5], 1'b0}; // see R06
    end
  end

  // Per-bank state; with no command only timer steps and burst ends move a bank, see R27
  for (genvar b = 0; b < lpcs_pkg::BANKS; b++) begin : g_bank
    logic hit;
    logic bst_here;
    logic done_here;
    assign hit = (ba == 3'(b));
    assign bst_here = acc_bst && (burst_bank == 3'(b));
    assign done_here = burst_done && (burst_bank == 3'(b));

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        bk_state[b] <= lpcs_pkg::BK_IDLE;
        bk_tmr[b] <= '0;
      end else if (acc_rst) begin
        bk_state[b] <= lpcs_pkg::BK_IDLE;
        bk_tmr[b] <= '0;
      end else if ((acc_pre && hit) || (acc_prea && bk_state[b] != lpcs_pkg::BK_REFRESHING)) begin
        bk_state[b] <= lpcs_pkg::BK_PRECHARGING;
        bk_tmr[b] <= lpcs_pkg::BK_TMR_W'(lpcs_pkg::RP_CYC);
      end else begin
        case (bk_state[b])
          lpcs_pkg::BK_IDLE: begin
            if (acc_act && hit) begin
              bk_state[b] <= lpcs_pkg::BK_ACTIVATING; // see R18
              bk_tmr[b] <= lpcs_pkg::BK_TMR_W'(lpcs_pkg::RCD_CYC);
            end else if ((acc_refpb && hit) || acc_refab) begin
              bk_state[b] <= lpcs_pkg::BK_REFRESHING; // see R18
              bk_tmr[b] <= acc_refab ? lpcs_pkg::BK_TMR_W'(lpcs_pkg::RFCAB_CYC)
                                     : lpcs_pkg::BK_TMR_W'(lpcs_pkg::RFCPB_CYC);
            end
          end
          lpcs_pkg::BK_ACTIVATING: begin
            if (bk_tmr[b] == lpcs_pkg::BK_TMR_W'(1)) begin
              bk_state[b] <= lpcs_pkg::BK_ACTIVE; // see R24
            end
            bk_tmr[b] <= bk_tmr[b] - 1'b1;
          end
          lpcs_pkg::BK_PRECHARGING, lpcs_pkg::BK_REFRESHING: begin
            if (bk_tmr[b] == lpcs_pkg::BK_TMR_W'(1)) begin
              bk_state[b] <= lpcs_pkg::BK_IDLE; // see R23
            end
            bk_tmr[b] <= bk_tmr[b] - 1'b1;
          end
          default: begin
            if (acc_rd && hit) begin
              bk_state[b] <= lpcs_pkg::BK_READING; // see R20 R21 R22
            end else if (acc_wr && hit) begin
              bk_state[b] <= lpcs_pkg::BK_WRITING; // see R20 R21 R22
            end else if (bst_here) begin
              bk_state[b] <= lpcs_pkg::BK_ACTIVE; // see R25
            end else if (done_here && burst_ap) begin
              bk_state[b] <= lpcs_pkg::BK_PRECHARGING; // see R03
              bk_tmr[b] <= lpcs_pkg::BK_TMR_W'(lpcs_pkg::RP_CYC);
            end else if (done_here) begin
              bk_state[b] <= lpcs_pkg::BK_ACTIVE;
            end
          end
        endcase
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        bank_idle[b] <= 1'b1;
        bank_open[b] <= 1'b0;
      end else begin
        bank_idle[b] <= (bk_state[b] == lpcs_pkg::BK_IDLE);
        bank_open[b] <= (bk_state[b] == lpcs_pkg::BK_ACTIVE);
      end
    end
  end

  // Status flags lag the internal state by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_done <= 1'b0;
      exit_wait <= 1'b0;
      cmd_illegal <= 1'b0;
    end else begin
      init_done <= (init_tmr == '0) && (dev_state != lpcs_pkg::DS_POWER_ON);
      exit_wait <= (exit_tmr != '0);
      cmd_illegal <= next_illegal; // see R16
    end
  end

  sequence s_act_bank0;
    acc_act && ba == 3'h0;
  endsequence

  property p_pd_entry;
    @(posedge clk) disable iff (!arst_n)
    dev_state == lpcs_pkg::DS_NORMAL && cke_prev && !cke && cs_n && all_idle |=> dev_state == lpcs_pkg::DS_IDLE_PD;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entry missed"); // see R07

  property p_pd_hold;
    @(posedge clk) disable iff (!arst_n)
    (dev_state == lpcs_pkg::DS_IDLE_PD || dev_state == lpcs_pkg::DS_ACT_PD) && !cke_prev && !cke |=> $stable(dev_state);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down not held"); // see R08

  property p_pd_exit;
    @(posedge clk) disable iff (!arst_n)
    (dev_state == lpcs_pkg::DS_ACT_PD || dev_state == lpcs_pkg::DS_IDLE_PD) && !cke_prev && cke && cs_n
      |=> dev_state == lpcs_pkg::DS_NORMAL && exit_tmr == lpcs_pkg::DEV_TMR_W'(lpcs_pkg::XP_CYC);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down exit wrong"); // see R09

  property p_dpd_exit;
    @(posedge clk) disable iff (!arst_n)
    dev_state == lpcs_pkg::DS_DPD && wake |=> dev_state == lpcs_pkg::DS_POWER_ON;
  endproperty
  a_dpd_exit: assert property (p_dpd_exit) else $error("deep power-down exit wrong"); // see R12

  property p_activate;
    @(posedge clk) disable iff (!arst_n)
    s_act_bank0 |=> bk_state[0] == lpcs_pkg::BK_ACTIVATING ##5 bk_state[0] == lpcs_pkg::BK_ACTIVE;
  endproperty
  a_activate: assert property (p_activate) else $error("activate timing wrong"); // see R24

  property p_auto_pre;
    @(posedge clk) disable iff (!arst_n)
    burst_done && burst_ap && !acc_rd && !acc_wr && !acc_prea && !acc_pre && !acc_rst
      |=> bk_state[$past(burst_bank)] == lpcs_pkg::BK_PRECHARGING;
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("auto-precharge missed"); // see R03

  property p_col;
    @(posedge clk) disable iff (!arst_n)
    acc_rd || acc_wr |=> col_addr == {$past(ca_f[9:1]), $past(ca_r[6:5]), 1'b0};
  endproperty
  a_col: assert property (p_col) else $error("column address wrong"); // see R06

  property p_bst;
    @(posedge clk) disable iff (!arst_n)
    acc_bst |=> !burst_busy && bk_state[$past(burst_bank)] == lpcs_pkg::BK_ACTIVE;
  endproperty
  a_bst: assert property (p_bst) else $error("burst stop wrong"); // see R25

  property p_reset;
    @(posedge clk) disable iff (!arst_n)
    acc_rst |=> dev_state == lpcs_pkg::DS_RESETTING && init_tmr == lpcs_pkg::INIT_TMR_W'(lpcs_pkg::INIT5_CYC);
  endproperty
  a_reset: assert property (p_reset) else $error("reset command ignored"); // see R19

  property p_exit_block;
    @(posedge clk) disable iff (!arst_n)
    cmd_slot && exit_tmr != '0 |=> cmd_illegal;
  endproperty
  a_exit_block: assert property (p_exit_block) else $error("command taken during exit"); // see R17
endmodule
`default_nettype wire

// ### dv/lpcs_host.sv
// Controller model that drives the command bus
`timescale 1ns/1ns
`default_nettype none
module lpcs_host (
  // Clock
  input wire logic clk,
  // Command bus
  output logic cke,
  output logic cs_n,
  output logic [9:0] ca_r,
  output logic [9:0] ca_f
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    ca_r = 10'h155;
    ca_f = 10'h2aa;
  end
  // One edge of command, then NOP; stale bits inverted so none look held
  task automatic cmd(input logic k, input logic s, input logic [9:0] r, input logic [9:0] f);
    @(negedge clk);
    cke = k;
    cs_n = s;
    ca_r = r;
    ca_f = f;
    @(negedge clk);
    cs_n = 1'b1;
    ca_r = ~r;
    ca_f = ~f;
  endtask
endmodule
`default_nettype wire

// ### dv/test_lpcs_command_state.sv
// Directed bench for the command and state logic
`timescale 1ns/1ns
`default_nettype none
module test_lpcs_command_state;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  wire logic cke;
  wire logic cs_n;
  wire logic [9:0] ca_r;
  wire logic [9:0] ca_f;
  lpcs_pkg::lpcs_dev_t dev_state;
  logic init_done, exit_wait, cmd_illegal, burst_busy, burst_read, ill_seen;
  logic [7:0] bank_idle, bank_open;
  logic [2:0] burst_bank;
  logic [11:0] col_addr;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  // Pulse is caught here so its exact cycle need not be guessed
  always @(posedge clk) if (cmd_illegal === 1'b1) ill_seen <= 1'b1;
  lpcs_host u_host (.clk(clk), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f));
  lpcs_command_state u_dut (.clk(clk), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f),
    .dev_state(dev_state), .init_done(init_done), .exit_wait(exit_wait), .cmd_illegal(cmd_illegal),
    .bank_idle(bank_idle), .bank_open(bank_open), .burst_busy(burst_busy), .burst_read(burst_read),
    .burst_bank(burst_bank), .col_addr(col_addr));
  task automatic chk_st(input lpcs_pkg::lpcs_dev_t e);
    samples_checked++;
    if (dev_state !== e) begin
      error_cnt++;
      $display("BAD t=%0t state got %h exp %h", $time, dev_state, e);
    end
  endtask
  task automatic chk_v(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_init;
    chk_st(lpcs_pkg::DS_POWER_ON);
    chk_v({4'h0, bank_idle}, 12'h0ff);
    u_host.cmd(1'b1, 1'b0, 10'h3f0, 10'h000);
    idle(2);
    chk_st(lpcs_pkg::DS_RESETTING);
    u_host.cmd(1'b0, 1'b1, 10'h0, 10'h0);
    idle(2);
    chk_st(lpcs_pkg::DS_RST_PD);
    u_host.cmd(1'b1, 1'b1, 10'h0, 10'h0);
    idle(2);
    chk_st(lpcs_pkg::DS_RESETTING);
    for (int i = 0; i < 2700 && dev_state !== lpcs_pkg::DS_NORMAL; i++) idle(1);
    idle(2);
    chk_st(lpcs_pkg::DS_NORMAL);
    chk_v({11'h0, init_done}, 12'h001);
    $display("init done");
  endtask
  task automatic t_bank;
    u_host.cmd(1'b1, 1'b0, 10'h182, 10'h0);
    idle(8);
    chk_v({bank_open, bank_idle[3], 3'h0}, 12'h080);
    u_host.cmd(1'b1, 1'b0, 10'h1e5, 10'h2a9);
    idle(1);
    chk_v({burst_busy, burst_read, 7'h0, burst_bank}, 12'hc03);
    chk_v(col_addr, 12'haa6);
    idle(12);
    chk_v({bank_open, bank_idle[3], 3'h0}, 12'h008);
    ill_seen = 1'b0;
    u_host.cmd(1'b1, 1'b0, 10'h1e5, 10'h0);
    idle(3);
    chk_v({11'h0, ill_seen}, 12'h001);
    chk_v({4'h0, bank_open}, 12'h000);
    $display("bank done");
  endtask
  task automatic t_power;
    u_host.cmd(1'b0, 1'b1, 10'h0, 10'h0);
    idle(2);
    chk_st(lpcs_pkg::DS_IDLE_PD);
    u_host.cmd(1'b0, 1'b0, 10'h182, 10'h0);
    idle(2);
    chk_st(lpcs_pkg::DS_IDLE_PD);
    u_host.cmd(1'b1, 1'b1, 10'h0, 10'h0);
    // Activate sent inside the exit interval must be refused
    ill_seen = 1'b0;
    u_host.cmd(1'b1, 1'b0, 10'h002, 10'h0);
    idle(2);
    chk_v({3'h0, ill_seen, bank_idle}, 12'h1ff);
    chk_st(lpcs_pkg::DS_NORMAL);
    idle(4);
    u_host.cmd(1'b0, 1'b0, 10'h004, 10'h0);
    idle(4);
    chk_st(lpcs_pkg::DS_SREF);
    u_host.cmd(1'b1, 1'b1, 10'h0, 10'h0);
    idle(6);
    chk_st(lpcs_pkg::DS_NORMAL);
    idle(40);
    $display("power done");
  endtask
  task automatic t_more;
    u_host.cmd(1'b1, 1'b0, 10'h282, 10'h0);
    idle(6);
    u_host.cmd(1'b1, 1'b0, 10'h281, 10'h0);
    u_host.cmd(1'b1, 1'b0, 10'h003, 10'h0);
    idle(1);
    chk_v({burst_busy, burst_read, 7'h0, burst_bank}, 12'h005);
    chk_v({4'h0, bank_open}, 12'h020);
    u_host.cmd(1'b1, 1'b0, 10'h104, 10'h0);
    idle(1);
    chk_v({4'h0, bank_idle}, 12'h0db);
    u_host.cmd(1'b1, 1'b0, 10'h01b, 10'h0);
    idle(20);
    u_host.cmd(1'b0, 1'b0, 10'h007, 10'h0);
    idle(4);
    chk_st(lpcs_pkg::DS_DPD);
    u_host.cmd(1'b1, 1'b1, 10'h0, 10'h0);
    idle(6);
    chk_st(lpcs_pkg::DS_POWER_ON);
    $display("more done");
  endtask
  initial begin
    ill_seen = 1'b0;
    idle(4);
    arst_n = 1'b1;
    idle(2);
    t_init();
    t_bank();
    t_power();
    t_more();
    t_init();
    complete_run();
  end
  // Whole run is about 5200 cycles, two init intervals
  initial begin
    #60000;
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
